/* File: design/phlo_consts.svh */
// Constants for the peripheral handshake line output block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PHLO_CONSTS_SVH
`define PHLO_CONSTS_SVH

// Register word indexes, byte address is four times the index
`define PHLO_IDX_A_DATA 3'h0
`define PHLO_IDX_A_CTRL 3'h1
`define PHLO_IDX_B_DATA 3'h2
`define PHLO_IDX_B_CTRL 3'h3
`define PHLO_IDX_STATUS 3'h4
`define PHLO_IDX_MASK 3'h5

// Control register reset value and writable bits
`define PHLO_CTRL_RESET 8'h00
`define PHLO_CTRL_WR_MASK 8'h3F

// Second control line mode codes (control bits 5,4,3)
`define PHLO_MODE_HANDSHAKE 3'h4
`define PHLO_MODE_PULSE 3'h5
`define PHLO_MODE_MANUAL_HI2 2'h3

// Reset values of the data side and the line level
`define PHLO_DATA_RESET 8'h00
`define PHLO_LINE_RESET 1'h1
`define PHLO_IRQ_RESET 2'h0

`endif

/* File: design/phlo_pkg.sv */
// Types shared by the handshake line output block.
// Assumes phlo_consts.svh is on the include path.
package phlo_pkg;
   `include "phlo_consts.svh"

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic flag1;        // Strobe edge seen, read only
      logic flag2;        // Line input edge seen, input modes not built
      logic [2:0] line_mode; // Second control line mode bits 5,4,3
      logic ddr_sel;      // One selects the data register, zero direction
      logic edge_pos;     // One picks a rising strobe edge
      logic irq_en;       // Strobe interrupt pin enable
   } phlo_ctrl_t;

   // Decoded line mode, one-hot
   typedef enum logic [3:0] {
      PHLO_LM_INPUT = 4'h1,
      PHLO_LM_HSHAKE = 4'h2,
      PHLO_LM_PULSE = 4'h4,
      PHLO_LM_MANUAL = 4'h8
   } phlo_line_mode_t;

   // One bus request as the slave sees it
   typedef struct packed {
      logic read;
      logic write;
      logic [2:0] address;
      logic [31:0] writedata;
   } phlo_req_t;
endpackage

/* File: design/phlo_top.sv */
// Two-port adapter core: data, direction and control registers per port,
// strobe edge detection and second control line output modes.
// Assumes an Avalon-MM master on core_clk and asynchronous port pins.
`include "phlo_consts.svh"

module phlo_top
   import phlo_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [7:0] porta_pins_in,
   output logic [7:0] porta_pins_out,
   output logic [7:0] porta_pins_oe,
   input wire logic [7:0] portb_pins_in,
   output logic [7:0] portb_pins_out,
   output logic [7:0] portb_pins_oe,
   input wire logic porta_strobe_in,
   input wire logic portb_strobe_in,
   output logic porta_handshake_line,
   output logic porta_handshake_line_oe,
   output logic portb_handshake_line,
   output logic portb_handshake_line_oe,
   output logic porta_irq_n,
   output logic portb_irq_n,
   output logic irq
);

   // Bus request bundled for decoding
   phlo_req_t req;
   // High in the cycle after a request was first seen
   logic done_reg;
   // Read data captured in the wait cycle
   logic [31:0] readdata_reg;
   // Shared event status and mask
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   logic [1:0] status_next;

   // Per-port state, one element per port
   phlo_ctrl_t ctrl_reg [2];
   logic [7:0] out_reg [2];
   logic [7:0] ddr_reg [2];
   logic [7:0] pin_s1_reg [2];
   logic [7:0] pin_s2_reg [2];
   logic strobe_s1_reg [2];
   logic strobe_s2_reg [2];
   logic strobe_prev_reg [2];
   logic line_reg [2];

   // Per-port decode and events
   logic [7:0] pins_in [2];
   logic [31:0] data_view [2];
   logic [1:0] strobe_edge;
   logic [1:0] data_trig;
   logic [1:0] data_rd;
   logic [1:0] data_wr;
   phlo_line_mode_t line_mode [2];

   // Bus decode wires
   wire bus_req = avs_read | avs_write;
   wire accept = bus_req & done_reg & clk_en;
   wire hit_status = (req.address == `PHLO_IDX_STATUS);
   wire hit_mask = (req.address == `PHLO_IDX_MASK);
   wire wr_status = accept & req.write & hit_status;
   wire wr_mask = accept & req.write & hit_mask;

   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata};

   // One wait state on every access; frozen clock enable keeps the wait
   assign avs_waitrequest = bus_req & ~accept;
   assign avs_readdata = readdata_reg;

   // Map the pins into per-port arrays
   assign pins_in[0] = porta_pins_in;
   assign pins_in[1] = portb_pins_in;
   assign porta_pins_out = out_reg[0];
   assign porta_pins_oe = ddr_reg[0];
   assign portb_pins_out = out_reg[1];
   assign portb_pins_oe = ddr_reg[1];

   // Line levels and enables; the line is only driven in output modes
   assign porta_handshake_line = line_reg[0];
   assign portb_handshake_line = line_reg[1];
   assign porta_handshake_line_oe = ctrl_reg[0].line_mode[2];
   assign portb_handshake_line_oe = ctrl_reg[1].line_mode[2];

   // Per-port interrupt pins follow flag and enable
   assign porta_irq_n = ~(ctrl_reg[0].flag1 & ctrl_reg[0].irq_en);
   assign portb_irq_n = ~(ctrl_reg[1].flag1 & ctrl_reg[1].irq_en);

   // Shared interrupt is a level while any unmasked event is pending
   assign irq = |(status_reg & mask_reg);

   // Status: write one to clear, a new event in the same cycle wins
   assign status_next = (status_reg & ~(wr_status ? req.writedata[1:0] : 2'h0))
                        | strobe_edge;

   // Bus handshake, request seen then answered
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         done_reg <= 1'h0;
      end else if (clk_en) begin
         done_reg <= bus_req & ~done_reg;
      end
   end

   // Read data is taken in the wait cycle and held through the answer
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         readdata_reg <= 32'h0;
      end else if (clk_en && avs_read && !done_reg) begin
         case (req.address)
            `PHLO_IDX_A_DATA, `PHLO_IDX_A_CTRL: readdata_reg <= data_view[0];
            `PHLO_IDX_B_DATA, `PHLO_IDX_B_CTRL: readdata_reg <= data_view[1];
            `PHLO_IDX_STATUS: readdata_reg <= {30'h0, status_reg};
            `PHLO_IDX_MASK: readdata_reg <= {30'h0, mask_reg};
            default: readdata_reg <= 32'h0; // Unmapped reads as zero
         endcase
      end
   end

   // Shared status and mask registers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         status_reg <= `PHLO_IRQ_RESET;
         mask_reg <= `PHLO_IRQ_RESET;
      end else if (clk_en) begin
         status_reg <= status_next;
         if (wr_mask) begin
            mask_reg <= req.writedata[1:0];
         end
      end
   end

   // Port logic, port 0 is A (read side), port 1 is B (write side)
   for (genvar g = 0; g < 2; g++) begin : g_port
      localparam logic [2:0] DATA_IDX = (g == 0) ? `PHLO_IDX_A_DATA : `PHLO_IDX_B_DATA;
      localparam logic [2:0] CTRL_IDX = (g == 0) ? `PHLO_IDX_A_CTRL : `PHLO_IDX_B_CTRL;
      logic line_next;
      phlo_ctrl_t ctrl_next;
      wire hit_data = (req.address == DATA_IDX);
      wire hit_ctrl = (req.address == CTRL_IDX);
      wire wr_ctrl = accept & req.write & hit_ctrl;
      wire wr_ddr = accept & req.write & hit_data & ~ctrl_reg[g].ddr_sel;
      // A port A view shows the pins; port B shows its own driven bits and the pins elsewhere
      wire [7:0] pin_view = (g == 0) ? pin_s2_reg[g] :
                            ((out_reg[g] & ddr_reg[g]) | (pin_s2_reg[g] & ~ddr_reg[g]));
      wire [7:0] data_byte = ctrl_reg[g].ddr_sel ? pin_view : ddr_reg[g];

      assign data_view[g] = hit_ctrl ? {24'h0, ctrl_reg[g]} : {24'h0, data_byte};

      // Data access strobes, only with the data register selected
      assign data_rd[g] = accept & req.read & hit_data & ctrl_reg[g].ddr_sel;
      assign data_wr[g] = accept & req.write & hit_data & ctrl_reg[g].ddr_sel;
      // Port A reacts to reads, port B to writes
      assign data_trig[g] = (g == 0) ? data_rd[g] : data_wr[g];

      // Edge of the synchronised strobe, polarity from bit 1
      assign strobe_edge[g] = ctrl_reg[g].edge_pos ?
                              (strobe_s2_reg[g] & ~strobe_prev_reg[g]) :
                              (~strobe_s2_reg[g] & strobe_prev_reg[g]);

      // Decode the mode bits into the one-hot mode
      assign line_mode[g] =
         !ctrl_reg[g].line_mode[2] ? PHLO_LM_INPUT :
         (ctrl_reg[g].line_mode[2:1] == `PHLO_MODE_MANUAL_HI2) ? PHLO_LM_MANUAL :
         (ctrl_reg[g].line_mode == `PHLO_MODE_PULSE) ? PHLO_LM_PULSE :
         PHLO_LM_HSHAKE;

      // Control next value: flag set wins over the clear by a data read
      always_comb begin
         ctrl_next = ctrl_reg[g];
         if (wr_ctrl) begin
            ctrl_next = phlo_ctrl_t'((ctrl_reg[g] & ~`PHLO_CTRL_WR_MASK)
                                     | (req.writedata[7:0] & `PHLO_CTRL_WR_MASK));
         end
         if (data_rd[g]) begin
            ctrl_next.flag1 = 1'h0;
         end
         if (strobe_edge[g]) begin
            ctrl_next.flag1 = 1'h1;
         end
         ctrl_next.flag2 = 1'h0; // Input modes of the line are not built
      end

      // Line next value per mode
      always_comb begin
         line_next = line_reg[g];
         case (line_mode[g])
            PHLO_LM_HSHAKE: begin
               // Port A: a new strobe edge beats a read of older data
               if (strobe_edge[g]) begin
                  line_next = 1'h1;
               end else if (data_trig[g]) begin
                  line_next = 1'h0;
               end
               // Port B: fresh data written beats the old acknowledge
               if (g == 1 && data_trig[g]) begin
                  line_next = 1'h0;
               end
            end
            PHLO_LM_PULSE: line_next = ~data_trig[g];
            PHLO_LM_MANUAL: line_next = ctrl_reg[g].line_mode[0];
            PHLO_LM_INPUT: line_next = `PHLO_LINE_RESET; // Idle high when undriven
            default: line_next = `PHLO_LINE_RESET;
         endcase
      end

      // Synchronisers for pins and strobe; stage two is read, and the strobe's delayed copy of stage two
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            pin_s1_reg[g] <= 8'h00;
            pin_s2_reg[g] <= 8'h00;
            strobe_s1_reg[g] <= 1'h0;
            strobe_s2_reg[g] <= 1'h0;
            strobe_prev_reg[g] <= 1'h0;
         end else if (clk_en) begin
            pin_s1_reg[g] <= pins_in[g];
            pin_s2_reg[g] <= pin_s1_reg[g];
            strobe_s1_reg[g] <= (g == 0) ? porta_strobe_in : portb_strobe_in;
            strobe_s2_reg[g] <= strobe_s1_reg[g];
            strobe_prev_reg[g] <= strobe_s2_reg[g];
         end
      end

      // Register file of the port
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            ctrl_reg[g] <= phlo_ctrl_t'(`PHLO_CTRL_RESET);
            out_reg[g] <= `PHLO_DATA_RESET;
            ddr_reg[g] <= `PHLO_DATA_RESET;
         end else if (clk_en) begin
            ctrl_reg[g] <= ctrl_next;
            if (data_wr[g]) begin
               out_reg[g] <= req.writedata[7:0];
            end
            if (wr_ddr) begin
               ddr_reg[g] <= req.writedata[7:0];
            end
         end
      end

      // Line flip-flop, high out of reset
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            line_reg[g] <= `PHLO_LINE_RESET;
         end else if (clk_en) begin
            line_reg[g] <= line_next;
         end
      end
   end

   // Checks of the line behaviour and the bus
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_a_hs_high;
      clk_en && line_mode[0] == PHLO_LM_HSHAKE && strobe_edge[0] |=> line_reg[0];
   endproperty
   a_a_hs_high: assert property (p_a_hs_high)
      else $error("port A line not high after strobe edge");

   property p_a_hs_low;
      clk_en && line_mode[0] == PHLO_LM_HSHAKE && data_rd[0] && !strobe_edge[0]
      |=> !line_reg[0];
   endproperty
   a_a_hs_low: assert property (p_a_hs_low)
      else $error("port A line not low after data read");

   property p_a_pulse;
      (clk_en && line_mode[0] == PHLO_LM_PULSE && data_rd[0])
      ##1 (clk_en && line_mode[0] == PHLO_LM_PULSE) |-> !line_reg[0] ##1 line_reg[0];
   endproperty
   a_a_pulse: assert property (p_a_pulse)
      else $error("port A pulse not exactly one cycle");

   property p_a_manual;
      clk_en && line_mode[0] == PHLO_LM_MANUAL |=> line_reg[0] == $past(ctrl_reg[0].line_mode[0]);
   endproperty
   a_a_manual: assert property (p_a_manual)
      else $error("port A manual level wrong");

   property p_b_hs_low;
      clk_en && line_mode[1] == PHLO_LM_HSHAKE && data_wr[1] |=> !line_reg[1];
   endproperty
   a_b_hs_low: assert property (p_b_hs_low)
      else $error("port B line not low after data write");

   property p_b_hs_high;
      clk_en && line_mode[1] == PHLO_LM_HSHAKE && strobe_edge[1] && !data_wr[1]
      |=> line_reg[1];
   endproperty
   a_b_hs_high: assert property (p_b_hs_high)
      else $error("port B line not high after strobe edge");

   property p_b_pulse;
      (clk_en && line_mode[1] == PHLO_LM_PULSE && data_wr[1])
      ##1 (clk_en && line_mode[1] == PHLO_LM_PULSE) |-> !line_reg[1] ##1 line_reg[1];
   endproperty
   a_b_pulse: assert property (p_b_pulse)
      else $error("port B pulse not exactly one cycle");

   property p_b_manual;
      clk_en && line_mode[1] == PHLO_LM_MANUAL |=> line_reg[1] == $past(ctrl_reg[1].line_mode[0]);
   endproperty
   a_b_manual: assert property (p_b_manual)
      else $error("port B manual level wrong");

   property p_data_read;
      clk_en && line_mode[0] == PHLO_LM_PULSE && avs_read && !avs_waitrequest
      && avs_address == `PHLO_IDX_A_DATA && ctrl_reg[0].ddr_sel |=> !porta_handshake_line;
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("port A data read did not pulse the line");

   property p_flag_set;
      clk_en && strobe_edge[0] |=> ctrl_reg[0].flag1 && status_reg[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("strobe edge did not set flag");

   property p_reset_high;
      !$past(resetn) |-> porta_handshake_line && portb_handshake_line;
   endproperty
   a_reset_high: assert property (p_reset_high)
      else $error("line not high after reset");

endmodule

/* File: verification/phlo_periph_model.sv */
// Peripheral device model facing the two handshake lines and the port pins.
// Assumes one shared core_clk; strobes change only right after a rising edge.
module phlo_periph_model (
   input wire logic core_clk,
   input wire logic porta_handshake_line,
   input wire logic portb_handshake_line,
   output logic porta_strobe_in,
   output logic portb_strobe_in,
   output logic [7:0] porta_pins_in,
   output logic [7:0] portb_pins_in
);
   timeunit 1ns;
   timeprecision 1ps;

   int taken_count; // Port A falls seen, data taken by the processor
   int avail_count; // Port B falls seen, new data offered
   logic a_q; // Last port A line level
   logic b_q; // Last port B line level

   // Idle levels and fixed pin patterns, B pins are only read where not driven
   initial begin
      porta_strobe_in = 1'h0;
      portb_strobe_in = 1'h0;
      porta_pins_in = 8'h5A;
      portb_pins_in = 8'hC3;
      taken_count = 0;
      avail_count = 0;
      a_q = 1'h1;
      b_q = 1'h1;
   end

   // Count falling line edges as notices from the adapter
   always @(posedge core_clk) begin
      a_q <= porta_handshake_line;
      b_q <= portb_handshake_line;
      if (a_q === 1'h1 && porta_handshake_line === 1'h0) begin
         taken_count <= taken_count + 1;
      end
      if (b_q === 1'h1 && portb_handshake_line === 1'h0) begin
         avail_count <= avail_count + 1;
      end
   end

   // Raise a strobe for some cycles, rising edge first, falling edge last
   task automatic strobe(input bit b, input int hold);
      @(posedge core_clk);
      if (b) portb_strobe_in <= 1'h1;
      else porta_strobe_in <= 1'h1;
      repeat (hold) @(posedge core_clk);
      if (b) portb_strobe_in <= 1'h0;
      else porta_strobe_in <= 1'h0;
   endtask
endmodule

/* File: verification/tb_phlo_top.sv */
// Self-checking bench for the handshake line output block.
// Assumes phlo_consts.svh on the include path and the peripheral model beside it.
`include "phlo_consts.svh"
module tb_phlo_top;
   timeunit 1ns;
   timeprecision 1ps;
   import phlo_pkg::*;

   logic core_clk, resetn, clk_en, avs_read, avs_write, avs_waitrequest, irq;
   logic [2:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0] pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
   logic sa, sb, la, la_oe, lb, lb_oe, irqa_n, irqb_n;
   int err_count, compares, n0;

   phlo_top i_dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .porta_pins_in(pa_in), .porta_pins_out(pa_out),
      .porta_pins_oe(pa_oe), .portb_pins_in(pb_in), .portb_pins_out(pb_out),
      .portb_pins_oe(pb_oe), .porta_strobe_in(sa), .portb_strobe_in(sb),
      .porta_handshake_line(la), .porta_handshake_line_oe(la_oe),
      .portb_handshake_line(lb), .portb_handshake_line_oe(lb_oe),
      .porta_irq_n(irqa_n), .portb_irq_n(irqb_n), .irq(irq));

   phlo_periph_model i_model (.core_clk(core_clk), .porta_handshake_line(la),
      .portb_handshake_line(lb), .porta_strobe_in(sa), .portb_strobe_in(sb),
      .porta_pins_in(pa_in), .portb_pins_in(pb_in));

   // Free running 100 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end

   // Count every compare, report a mismatch at once
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; waitrequest and read data are taken at the rising edge only,
   // then the request is dropped at that same edge
   task automatic bus(input logic rd, input logic [2:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_read <= rd;
      avs_write <= ~rd;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 50);
      if (n >= 50) check(32'h00000000, 32'h00000001);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'h0, a, d, q);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h1, a, 8'h00, q);
      check(q, exp);
   endtask

   // Look at one line in the next settled cycle
   task automatic line_is(input bit b, input logic exp);
      @(negedge core_clk);
      check({31'h0, b ? lb : la}, {31'h0, exp});
   endtask

   // Strobe edges need synchronising, so allow a bounded wait
   task automatic wait_line(input bit b, input logic exp);
      int n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while ((b ? lb : la) !== exp && n < 20);
      check({31'h0, b ? lb : la}, {31'h0, exp});
   endtask

   task finish_test;
      $display("Compares %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Cut a hang short well past the expected run of a few hundred cycles
   initial begin
      #100000;
      err_count++;
      finish_test;
   end

   // Main sequence
   initial begin
      err_count = 0;
      compares = 0;
      resetn = 1'h0;
      clk_en = 1'h1;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_address = 3'h0;
      avs_writedata = 32'h00000000;
      repeat (3) @(posedge core_clk);
      resetn <= 1'h1;
      @(negedge core_clk);
      check({la, la_oe, lb, lb_oe, irq}, 32'h00000014);
      rd_chk(`PHLO_IDX_A_CTRL, 32'h00000000);
      // Top two control bits are read only
      wr(`PHLO_IDX_A_CTRL, 8'hFF);
      rd_chk(`PHLO_IDX_A_CTRL, 32'h0000003F);
      check({31'h0, la_oe}, 32'h00000001);
      // Unmapped index still answers, reads zero
      wr(3'h6, 8'hAA);
      rd_chk(3'h6, 32'h00000000);
      // Manual levels on both ports
      for (int b = 0; b < 2; b++) begin
         for (int k = 0; k < 3; k++) begin
            wr(b ? `PHLO_IDX_B_CTRL : `PHLO_IDX_A_CTRL, (k == 1) ? 8'h38 : 8'h30);
            @(posedge core_clk); // Manual level lands one cycle after the write
            line_is(b[0], k == 1);
         end
      end
      // Port A handshake on rising strobe edges
      wr(`PHLO_IDX_A_CTRL, 8'h26);
      i_model.strobe(1'h0, 2);
      wait_line(1'h0, 1'h1);
      rd_chk(`PHLO_IDX_A_CTRL, 32'h000000A6);
      check({31'h0, irqa_n}, 32'h00000001);
      rd_chk(`PHLO_IDX_A_DATA, 32'h0000005A);
      line_is(1'h0, 1'h0);
      rd_chk(`PHLO_IDX_A_CTRL, 32'h00000026);
      i_model.strobe(1'h0, 2);
      wait_line(1'h0, 1'h1);
      // Direction register read must not lower the line
      wr(`PHLO_IDX_A_CTRL, 8'h22);
      rd_chk(`PHLO_IDX_A_DATA, 32'h00000000);
      line_is(1'h0, 1'h1);
      // Direction write with bit 2 clear reaches the pin enables
      wr(`PHLO_IDX_A_DATA, 8'h0F);
      @(negedge core_clk);
      check({24'h0, pa_oe}, 32'h0000000F);
      // Status, mask and the summary interrupt
      wr(`PHLO_IDX_MASK, 8'h01);
      @(negedge core_clk);
      check({31'h0, irq}, 32'h00000001);
      wr(`PHLO_IDX_MASK, 8'h00);
      @(negedge core_clk);
      check({31'h0, irq}, 32'h00000000);
      wr(`PHLO_IDX_MASK, 8'h01);
      wr(`PHLO_IDX_STATUS, 8'h01);
      rd_chk(`PHLO_IDX_STATUS, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      // Strobe pin interrupt once enabled
      wr(`PHLO_IDX_A_CTRL, 8'h27);
      i_model.strobe(1'h0, 2);
      repeat (8) @(negedge core_clk);
      check({31'h0, irqa_n}, 32'h00000000);
      // Port A pulse, back to back reads
      wr(`PHLO_IDX_A_CTRL, 8'h2C);
      n0 = i_model.taken_count;
      for (int k = 0; k < 2; k++) begin
         rd_chk(`PHLO_IDX_A_DATA, 32'h0000005A);
         line_is(1'h0, 1'h0);
         line_is(1'h0, 1'h1);
      end
      check(i_model.taken_count - n0, 32'h00000002);
      // Port B handshake on falling strobe edges
      wr(`PHLO_IDX_B_CTRL, 8'h24);
      i_model.strobe(1'h1, 2);
      wait_line(1'h1, 1'h1);
      n0 = i_model.avail_count;
      wr(`PHLO_IDX_B_DATA, 8'h3C);
      line_is(1'h1, 1'h0);
      @(negedge core_clk); // The model counts the fall one edge later
      check(i_model.avail_count - n0, 32'h00000001);
      check({24'h0, pb_out}, 32'h0000003C);
      i_model.strobe(1'h1, 2);
      wait_line(1'h1, 1'h1);
      // Port A edge from the interrupt test is still pending in bit 0
      rd_chk(`PHLO_IDX_STATUS, 32'h00000003);
      wr(`PHLO_IDX_STATUS, 8'h02);
      rd_chk(`PHLO_IDX_STATUS, 32'h00000001);
      check({31'h0, irq}, 32'h00000001);
      // Port B pulse, back to back writes
      wr(`PHLO_IDX_B_CTRL, 8'h2C);
      for (int k = 0; k < 2; k++) begin
         wr(`PHLO_IDX_B_DATA, 8'hA5);
         line_is(1'h1, 1'h0);
         line_is(1'h1, 1'h1);
      end
      check({24'h0, pb_out}, 32'h000000A5);
      // A strobe while the clock enable is low must leave no trace
      clk_en <= 1'h0;
      i_model.strobe(1'h1, 2);
      repeat (4) @(posedge core_clk);
      clk_en <= 1'h1;
      rd_chk(`PHLO_IDX_STATUS, 32'h00000001);
      // Leaving the output modes releases the line high
      wr(`PHLO_IDX_A_CTRL, 8'h04);
      @(negedge core_clk);
      check({la, la_oe}, 32'h00000002);
      check({31'h0, irqb_n}, 32'h00000001);
      finish_test;
   end
endmodule
